//--- reset_clock_sequencer.sv
// Reset source collection, reset cause register and clock start-up sequencing
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module reset_clock_sequencer #(
    parameter int POR_CYCLES  = sequencer_pkg::POR_TIMEOUT,
    parameter int LONG_STOP   = sequencer_pkg::STOP_LONG,
    parameter int SHORT_STOP  = sequencer_pkg::STOP_SHORT
) (
    // Clock and power-on reset
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // Reset sources and pin
    input  wire sequencer_pkg::reset_req_t reset_req,
    input  wire logic                      reset_pin_n,
    // Core mode inputs
    input  wire logic                      stop_req,
    input  wire logic                      wait_req,
    input  wire logic                      wake_irq,
    input  wire logic                      monitor_mode,
    input  wire logic                      break_state,
    // Outputs to core and modules
    output logic                           internal_reset_signal,
    output logic [15:0]                    reset_vector,
    output sequencer_pkg::clock_gate_t     clock_gate,
    output logic                           status_clear_allow,
    // AXI4-Lite write channels
    input  wire logic [7:0]                s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [7:0]                s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready
);
    localparam int W = sequencer_pkg::CNT_W;
    // Counts must fit the counter, or the target casts would wrap
    if (POR_CYCLES < 1 || POR_CYCLES >= (1 << W) || LONG_STOP < 1 || LONG_STOP >= (1 << W)
        || SHORT_STOP < 1 || SHORT_STOP >= (1 << W)) begin : g_bad
        $error("reset_clock_sequencer: delay counts out of range");
    end
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == sequencer_pkg::ADDR_CAUSE) || (a == sequencer_pkg::ADDR_BREAK)
                 || (a == sequencer_pkg::ADDR_CFG2) || (a == sequencer_pkg::ADDR_STOPCFG)
                 || (a == sequencer_pkg::ADDR_CLKSTAT);
    endfunction : is_mapped
    localparam int     HW = sequencer_pkg::HOLD_W;
    sequencer_pkg::seq_state_t state_q, state_d;
    logic [7:0]        cause_q, cause_d, cause_set, awaddr_q, araddr_q, wdata_q, rd_byte;
    logic [1:0]        div_q;
    logic [W-1:0]      seq_count, target;
    logic [HW-1:0]     hold_q;
    logic [3:0]        low_cnt_q;
    logic              cnt_done, cnt_clear, pin_sync, pin_low, pin_low_q, pin_counted_q, any_req, enter_reset;
    logic              clear_enable_q, pin_enable_q, short_stop_q, from_stop_q, long_stop_q, internal_reset_signal_q;
    logic              wbyte_q, aw_hold_q, w_hold_q, do_write, do_read, wr_ok, cause_rd, clear_ok;
    // Pin crosses two flops before anything reads it
    sync_two_ff u_pin_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (reset_pin_n),
        .sync_out (pin_sync)
    );
    assign pin_low = pin_enable_q && !pin_sync;
    // Sequence counter; only internal sources, stop entry and wake from stop clear it
    delay_counter #(.W(W)) u_count (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clear   (cnt_clear),
        .run     (state_q != sequencer_pkg::ST_STOPPED),
        .target  (target),
        .count   (seq_count),
        .done    (cnt_done)
    );
    // Internal source requests and the clear they cause
    assign any_req     = |reset_req;
    assign enter_reset = any_req || pin_low;
    assign cnt_clear   = any_req
                      || (state_q == sequencer_pkg::ST_RUN && stop_req)
                      || (state_q == sequencer_pkg::ST_STOPPED && wake_irq);
    assign target = (state_q == sequencer_pkg::ST_POWER_UP) ? W'(POR_CYCLES)
                  : (short_stop_q && !long_stop_q) ? W'(SHORT_STOP) : W'(LONG_STOP);
    // Next state; any reset request wins over every mode except power-up
    always_comb begin
        state_d = state_q;
        case (state_q)
            sequencer_pkg::ST_POWER_UP:  if (cnt_done) state_d = sequencer_pkg::ST_RUN;
            sequencer_pkg::ST_RUN: begin
                if (stop_req) state_d = sequencer_pkg::ST_STOPPED;
                else if (wait_req) state_d = sequencer_pkg::ST_WAITING;
            end
            sequencer_pkg::ST_WAITING:   if (wake_irq) state_d = sequencer_pkg::ST_RUN;
            sequencer_pkg::ST_STOPPED:   if (wake_irq) state_d = sequencer_pkg::ST_STOP_EXIT;
            sequencer_pkg::ST_STOP_EXIT: if (cnt_done) state_d = sequencer_pkg::ST_RUN;
            sequencer_pkg::ST_RST_HOLD: begin
                if (hold_q == '0 && !pin_low) begin
                    state_d = from_stop_q ? sequencer_pkg::ST_STOP_EXIT : sequencer_pkg::ST_RUN;
                end
            end
            default: state_d = sequencer_pkg::ST_POWER_UP;
        endcase
        if (enter_reset && state_q != sequencer_pkg::ST_POWER_UP) state_d = sequencer_pkg::ST_RST_HOLD;
    end
    // State, hold timer and stop bookkeeping
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q     <= sequencer_pkg::ST_POWER_UP;
            hold_q      <= '0;
            from_stop_q <= 1'b0;
            long_stop_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (enter_reset) hold_q <= HW'(sequencer_pkg::RST_HOLD_CYCLES);
            else if (hold_q != '0) hold_q <= hold_q - 1'b1;
            if (enter_reset && state_q != sequencer_pkg::ST_RST_HOLD) begin
                from_stop_q <= (state_q == sequencer_pkg::ST_STOPPED);
            end
            if (reset_req.low_voltage) long_stop_q <= 1'b1; // Low-voltage exit takes the long delay
            else if (state_q == sequencer_pkg::ST_RUN) long_stop_q <= 1'b0;
        end
    end
    // Internal reset and vector, registered so modules see a clean level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            internal_reset_signal_q       <= 1'b1;
            reset_vector <= sequencer_pkg::VEC_USER;
        end else begin
            internal_reset_signal_q <= (state_d == sequencer_pkg::ST_RST_HOLD);
            if (enter_reset) reset_vector <= monitor_mode ? sequencer_pkg::VEC_MONITOR
                                                          : sequencer_pkg::VEC_USER;
        end
    end
    assign internal_reset_signal = internal_reset_signal_q;
    // Bus clock divider runs only while the bus clocks are up
    always_ff @(posedge aclk) begin
        if (!aresetn || state_q != sequencer_pkg::ST_RUN) div_q <= '0;
        else div_q <= div_q + 1'b1;
    end
    // Clock enables: CPU only in run, peripherals also in wait
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clock_gate <= '0;
        end else begin
            clock_gate.bus_tick   <= (state_q == sequencer_pkg::ST_RUN) && (div_q == sequencer_pkg::BUS_DIV_LAST);
            clock_gate.cpu_run    <= (state_d == sequencer_pkg::ST_RUN);
            clock_gate.periph_run <= (state_d == sequencer_pkg::ST_RUN)
                                  || (state_d == sequencer_pkg::ST_WAITING);
        end
    end
    // Pin low-time measure; the flag needs one cycle less than the minimum
    always_ff @(posedge aclk) begin
        if (!aresetn || !pin_low) begin
            low_cnt_q <= '0;
        end else if (low_cnt_q != 4'(sequencer_pkg::MIN_LOW_CYCLES)) begin
            low_cnt_q <= low_cnt_q + 1'b1;
        end
        pin_low_q <= aresetn && pin_low;
    end
    assign pin_counted_q = pin_low_q && (low_cnt_q == 4'(sequencer_pkg::MIN_LOW_CYCLES - 1));
    // Flag sets, one bit per source
    always_comb begin
        cause_set = '0;
        cause_set[sequencer_pkg::BIT_PIN]         = pin_counted_q;
        cause_set[sequencer_pkg::BIT_WATCHDOG]    = reset_req.watchdog;
        cause_set[sequencer_pkg::BIT_BAD_OPCODE]  = reset_req.bad_opcode;
        cause_set[sequencer_pkg::BIT_BAD_ADDRESS] = reset_req.bad_address;
        cause_set[sequencer_pkg::BIT_DEBUG_ENTRY] = reset_req.debug_entry;
        cause_set[sequencer_pkg::BIT_LOW_VOLTAGE] = reset_req.low_voltage;
    end
    // Break gating: clears allowed outside break or with enable set
    assign status_clear_allow = !break_state || clear_enable_q;
    assign clear_ok = status_clear_allow;
    assign cause_rd = do_read && (araddr_q == sequencer_pkg::ADDR_CAUSE);
    // A set in the clearing cycle survives the clear
    assign cause_d = ((cause_rd && clear_ok) ? 8'h00 : cause_q) | cause_set;
    always_ff @(posedge aclk) begin
        if (!aresetn) cause_q <= sequencer_pkg::CAUSE_AT_POWER_ON;
        else cause_q <= cause_d;
    end
    // AXI write: address and data taken in either order
    assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
    assign do_write      = aw_hold_q && w_hold_q && !s_axi_bvalid;
    assign wr_ok         = is_mapped(awaddr_q);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q    <= 1'b0;
            w_hold_q     <= 1'b0;
            awaddr_q     <= '0;
            wdata_q      <= '0;
            wbyte_q      <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= sequencer_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q  <= s_axi_wdata[7:0];
                wbyte_q  <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_hold_q    <= 1'b0;
                w_hold_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? sequencer_pkg::RESP_OKAY : sequencer_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // Control registers; break enable returns to 0 on internal reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clear_enable_q <= 1'b0;
            pin_enable_q   <= 1'b1;
            short_stop_q   <= 1'b0;
        end else if (internal_reset_signal_q) begin
            clear_enable_q <= 1'b0;
        end else if (do_write && wbyte_q) begin
            if (awaddr_q == sequencer_pkg::ADDR_BREAK) clear_enable_q <= wdata_q[sequencer_pkg::BIT_CLEAR_ENABLE];
            else if (awaddr_q == sequencer_pkg::ADDR_CFG2) pin_enable_q <= wdata_q[sequencer_pkg::BIT_PIN_ENABLE];
            else if (awaddr_q == sequencer_pkg::ADDR_STOPCFG) short_stop_q <= wdata_q[sequencer_pkg::BIT_SHORT_STOP];
        end
    end
    // AXI read: one-cycle decode, data registered
    assign s_axi_arready = !s_axi_rvalid && !do_read;
    assign rd_byte = (araddr_q == sequencer_pkg::ADDR_CAUSE)   ? cause_q
                   : (araddr_q == sequencer_pkg::ADDR_BREAK)   ? {7'h00, clear_enable_q}
                   : (araddr_q == sequencer_pkg::ADDR_CFG2)    ? {7'h00, pin_enable_q}
                   : (araddr_q == sequencer_pkg::ADDR_STOPCFG) ? {7'h00, short_stop_q}
                   : (araddr_q == sequencer_pkg::ADDR_CLKSTAT) ? {2'h0, state_q, clock_gate}
                   : 8'h00;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            do_read      <= 1'b0;
            araddr_q     <= '0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= sequencer_pkg::RESP_OKAY;
        end else begin
            do_read <= s_axi_arvalid && s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) araddr_q <= s_axi_araddr;
            if (do_read) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rd_byte};
                s_axi_rresp  <= is_mapped(araddr_q) ? sequencer_pkg::RESP_OKAY : sequencer_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
    // Checks
    power_up_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q == sequencer_pkg::ST_POWER_UP) |=> !clock_gate.cpu_run || $past(cnt_done))
        else $error("cpu clock started before power-up timeout");
    bus_div_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clock_gate.bus_tick |=> !clock_gate.bus_tick [*3])
        else $error("bus tick not divided by four");
    stop_target_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q == sequencer_pkg::ST_STOP_EXIT) |->
        target == ((short_stop_q && !long_stop_q) ? W'(SHORT_STOP) : W'(LONG_STOP)))
        else $error("wrong stop exit delay");
    stop_clocks_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q == sequencer_pkg::ST_STOP_EXIT && !cnt_done) |=> !clock_gate.cpu_run)
        else $error("cpu clock running during stop delay");
    wait_clocks_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q == sequencer_pkg::ST_WAITING && !enter_reset && !wake_irq) |=>
        !clock_gate.cpu_run && clock_gate.periph_run)
        else $error("wait mode clocks wrong");
    source_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (any_req && state_q != sequencer_pkg::ST_POWER_UP) |=> internal_reset_signal [*2])
        else $error("reset source did not assert internal reset");
    counter_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        any_req |=> seq_count == '0)
        else $error("counter not cleared by internal reset");
    flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        reset_req.watchdog |=> cause_q[sequencer_pkg::BIT_WATCHDOG])
        else $error("watchdog flag not set");
    pin_halt_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (pin_low && state_q != sequencer_pkg::ST_POWER_UP) |=> ##1 internal_reset_signal)
        else $error("pin low did not halt");
    pin_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !pin_enable_q |-> !pin_low)
        else $error("pin reset acted while disabled");
    read_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (cause_rd && clear_ok && cause_set == '0) |=> cause_q == '0 && s_axi_rdata[7:0] == $past(cause_q))
        else $error("status read did not return then clear");
    break_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (cause_rd && !clear_ok) |=> (cause_q & $past(cause_q)) == $past(cause_q))
        else $error("status bits cleared during protected break");
    power_up_c: cover property (@(posedge aclk) disable iff (!aresetn)
        state_q == sequencer_pkg::ST_POWER_UP ##1 state_q == sequencer_pkg::ST_RUN);
    stop_exit_c: cover property (@(posedge aclk) disable iff (!aresetn)
        state_q == sequencer_pkg::ST_STOP_EXIT ##1 state_q == sequencer_pkg::ST_RUN);
    pin_flag_c: cover property (@(posedge aclk) disable iff (!aresetn)
        $rose(cause_q[sequencer_pkg::BIT_PIN]));
endmodule : reset_clock_sequencer
`default_nettype wire

//--- sequencer_pkg.sv
// Constants, types and register map of the reset and clock sequencer
package sequencer_pkg;

    // Clocking: quad-rate clock at 20 MHz
    localparam int          CLK_PERIOD_NS    = 50;
    localparam logic [1:0]  BUS_DIV_LAST     = 2'h3;   // Divide by four
    localparam int          POR_TIMEOUT      = 4096;
    localparam int          STOP_LONG        = 4096;
    localparam int          STOP_SHORT       = 32;
    localparam int          CNT_W            = 13;

    // Least low time on the reset pin, rounded up to whole cycles
    localparam int          MIN_RESET_LOW_NS = 200;
    localparam int          MIN_LOW_CYCLES   = (MIN_RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RST_HOLD_CYCLES  = 16;
    localparam int          HOLD_W           = 5;

    // Register byte addresses
    localparam logic [7:0]  ADDR_CAUSE       = 8'h00;
    localparam logic [7:0]  ADDR_BREAK       = 8'h04;
    localparam logic [7:0]  ADDR_CFG2        = 8'h08;
    localparam logic [7:0]  ADDR_STOPCFG     = 8'h0c;
    localparam logic [7:0]  ADDR_CLKSTAT     = 8'h10;

    // Reset cause flag positions
    localparam int          BIT_POWER_ON     = 7;
    localparam int          BIT_PIN          = 6;
    localparam int          BIT_WATCHDOG     = 5;
    localparam int          BIT_BAD_OPCODE   = 4;
    localparam int          BIT_BAD_ADDRESS  = 3;
    localparam int          BIT_DEBUG_ENTRY  = 2;
    localparam int          BIT_LOW_VOLTAGE  = 1;
    localparam logic [7:0]  CAUSE_AT_POWER_ON = 8'h80;

    // Control bit positions
    localparam int          BIT_CLEAR_ENABLE = 0;
    localparam int          BIT_PIN_ENABLE   = 0;
    localparam int          BIT_SHORT_STOP   = 0;

    // Reset vectors
    localparam logic [15:0] VEC_USER         = 16'hfffe;
    localparam logic [15:0] VEC_MONITOR      = 16'hfefe;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    // Sequencer states, Gray along power-up, run, wait and stop
    typedef enum logic [2:0] {
        ST_POWER_UP  = 3'b000,
        ST_RUN       = 3'b001,
        ST_WAITING   = 3'b011,
        ST_STOPPED   = 3'b010,
        ST_STOP_EXIT = 3'b110,
        ST_RST_HOLD  = 3'b111
    } seq_state_t;

    // Internal reset requests, one-cycle pulses from the same clock
    typedef struct packed {
        logic watchdog;
        logic low_voltage;
        logic bad_opcode;
        logic bad_address;
        logic debug_entry;
    } reset_req_t;

    // Clock gating enables
    typedef struct packed {
        logic bus_tick;
        logic cpu_run;
        logic periph_run;
    } clock_gate_t;

endpackage : sequencer_pkg

//--- sync_two_ff.sv
// Two flip-flop synchroniser for an asynchronous level
`timescale 1ns/100ps
`default_nettype none
module sync_two_ff (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Level in and out
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_q;

    // First stage feeds only the second; reset value is the pin's idle high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q   <= 1'b1;
            sync_out <= 1'b1;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : sync_two_ff
`default_nettype wire

//--- delay_counter.sv
// Free cycle counter with synchronous clear and hold
`timescale 1ns/100ps
`default_nettype none
module delay_counter #(
    parameter int W = 13
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Control
    input  wire logic         clear,
    input  wire logic         run,
    input  wire logic [W-1:0] target,
    // Status
    output logic [W-1:0]      count,
    output logic              done
);
    // Saturates so a long idle never wraps back below a target
    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            count <= '0;
        end else if (run && count != {W{1'b1}}) begin
            count <= count + 1'b1;
        end
    end

    assign done = (count >= target);
endmodule : delay_counter
`default_nettype wire

//--- pin_driver.sv
// Model of the board side of the reset pin
`timescale 1ns/100ps
`default_nettype none
module pin_driver (
    // Clock and command
    input  wire logic       aclk,
    input  wire logic       go,
    input  wire logic [7:0] low_len,
    // Pin with pull-up, high when released
    output logic            reset_pin_n
);
    int left = 0;
    // Holds the pin low for the asked cycles; short counts break the low time
    always @(posedge aclk) begin
        if (go) left <= low_len;
        else if (left != 0) left <= left - 1;
    end
    assign reset_pin_n = (left == 0);
endmodule : pin_driver
`default_nettype wire

//--- reset_clock_sequencer_test.sv
// Self-checking bench for the reset and clock sequencer
`timescale 1ns/100ps
`default_nettype none
module reset_clock_sequencer_test;
    logic aclk = 0, aresetn = 0, go = 0, stop_req = 0, wait_req = 0, wake_irq = 0, monitor_mode = 0, break_state = 0;
    logic reset_pin_n, internal_reset_signal, status_clear_allow;
    logic [15:0] reset_vector;
    sequencer_pkg::reset_req_t reset_req = '0;
    sequencer_pkg::clock_gate_t clock_gate;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, low_len = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int fail_count = 0, n_tests = 0, seed = 7312, ticks = 0, n = 0;
    int pos[5] = '{5, 1, 4, 3, 2};
    // Clock, design and pin model
    always #25 aclk = ~aclk;
    reset_clock_sequencer #(.POR_CYCLES(20), .LONG_STOP(20), .SHORT_STOP(4)) dut (.*);
    pin_driver pin (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask : axw
    // Read one word; the response code is checked on every read
    task automatic axr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 0;
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        chk(s_axi_rdata, exp);
    endtask : axr
    // Wait out an internal reset with a bound
    task automatic settle;
        repeat (6) @(posedge aclk);
        for (int i = 0; i < 80 && internal_reset_signal !== 1'b0; i++) @(posedge aclk);
        chk({31'h0, internal_reset_signal}, 0);
    endtask : settle
    task automatic pulse(input logic [7:0] len);
        @(posedge aclk);
        low_len <= len;
        go <= 1;
        @(posedge aclk);
        go <= 0;
    endtask : pulse
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    // Main sequence
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        repeat (10) @(posedge aclk);
        chk({31'h0, clock_gate.cpu_run}, 0);
        repeat (16) @(posedge aclk);
        chk({30'h0, clock_gate.cpu_run, clock_gate.periph_run}, 3);
        axr(8'h00, 32'h80, 2'h0);
        axr(8'h00, 32'h00, 2'h0);
        for (int k = 0; k < 5; k++) begin
            @(posedge aclk);
            monitor_mode <= 1'($random(seed));
            reset_req <= 5'h10 >> k;
            @(posedge aclk);
            reset_req <= '0;
            repeat (3) @(posedge aclk);
            chk({15'h0, internal_reset_signal, reset_vector},
                {15'h0, 1'b1, monitor_mode ? 16'hfefe : 16'hfffe});
            settle();
            axr(8'h00, 32'h1 << pos[k], 2'h0);
        end
        $display("internal sources done");
        pulse(8'h02);
        settle();
        axr(8'h00, 32'h00, 2'h0);
        pulse(8'h0a);
        repeat (6) @(posedge aclk);
        chk({31'h0, internal_reset_signal}, 1);
        settle();
        break_state <= 1;
        axr(8'h00, 32'h40, 2'h0);
        axr(8'h00, 32'h40, 2'h0);
        chk({31'h0, status_clear_allow}, 0);
        axw(8'h04, 32'h1, 2'h0);
        axr(8'h04, 32'h1, 2'h0);
        axr(8'h00, 32'h40, 2'h0);
        axr(8'h00, 32'h00, 2'h0);
        break_state <= 0;
        axw(8'h08, 32'h0, 2'h0);
        pulse(8'h0a);
        repeat (6) @(posedge aclk);
        chk({31'h0, internal_reset_signal}, 0);
        repeat (10) @(posedge aclk);
        axr(8'h00, 32'h00, 2'h0);
        axr(8'h14, 32'h00, 2'h2);
        axw(8'h14, 32'h1, 2'h2);
        $display("pin and bus done");
        // Wait mode stops the CPU clock but keeps the peripheral clock
        @(posedge aclk) wait_req <= 1;
        @(posedge aclk) wait_req <= 0;
        repeat (2) @(posedge aclk);
        chk({30'h0, clock_gate.cpu_run, clock_gate.periph_run}, 1);
        @(posedge aclk) wake_irq <= 1;
        @(posedge aclk) wake_irq <= 0;
        repeat (2) @(posedge aclk);
        chk({30'h0, clock_gate.cpu_run, clock_gate.periph_run}, 3);
        // Bus tick on every fourth quad-rate edge: two in any eight
        for (int i = 0; i < 8; i++) begin
            @(posedge aclk);
            ticks += clock_gate.bus_tick;
        end
        chk(ticks, 2);
        // Short then long stop recovery; stop-exit entry and the registered enable add two edges
        for (int s = 1; s >= 0; s--) begin
            axw(8'h0c, s, 2'h0);
            @(posedge aclk) stop_req <= 1;
            @(posedge aclk) stop_req <= 0;
            axr(8'h10, 32'h10, 2'h0);
            @(posedge aclk) wake_irq <= 1;
            @(posedge aclk) wake_irq <= 0;
            for (n = 0; n < 60 && !clock_gate.cpu_run; n++) @(posedge aclk);
            chk(n, s ? 6 : 22);
        end
        $display("clock modes done");
        wrap_up();
    end
    // Watchdog on a hang
    initial begin
        #(50 * 20000);
        fail_count++;
        wrap_up();
    end
endmodule : reset_clock_sequencer_test
`default_nettype wire
